// File: seq_defines.svh
// Constants of the sequence input decoder: register map, function codes, reset values.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// Register addresses (word index on the plain register port).
`define ADDR_COMP0 8'h01
`define ADDR_MODE_CFG 8'h09
`define ADDR_SPD1 8'h1F
`define ADDR_SPD2 8'h20
`define ADDR_SPD3 8'h21
`define ADDR_ACC0 8'h23
`define ADDR_DEC0 8'h24
`define ADDR_ACC1 8'h25
`define ADDR_DEC1 8'h26
`define ADDR_GAIN 8'h46
`define ADDR_COMP1 8'h4E
`define ADDR_COMP2 8'h4F
`define ADDR_COMP3 8'h50
`define ADDR_MAX_SPEED 8'h51
`define ADDR_ASSIGN_BASE 8'h60
`define ADDR_STATUS 8'h7F

// Terminal function codes.
`define FN_PULSE_INHIBIT 11
`define FN_COMP_SEL0 12
`define FN_COMP_SEL1 13
`define FN_MODE_SWITCH 14
`define FN_FORWARD 15
`define FN_REVERSE 16
`define FN_STEP_SEL0 17
`define FN_STEP_SEL1 18
`define FN_TIME_SEL 19

// Reset values.
`define RST_COMP 16'h0001
`define RST_GAIN 16'h1000
`define RST_MAX_SPEED 16'h1000
`define RST_MODE_CFG 3'h0

// Fixed-point shifts: analog full scale and gain with twelve fraction bits.
`define ADC_FS_SHIFT 13
`define GAIN_FRAC_SHIFT 12

`endif

// File: seq_pkg.sv
// Types shared by the sequence input decoder files.
package seq_pkg;
  typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_TRQ} ctrl_mode_e;
  typedef enum logic [1:0] {MOT_IDLE, MOT_POSITIVE, MOT_NEGATIVE} motion_e;
  typedef logic [15:0] word_t;
endpackage

// File: term_sync.sv
// Three-stage synchroniser with agreement filter for the sequence input pins.
`timescale 1ns/1ps
module term_sync #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and clean levels
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] level_out
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
  } sync_s;
  sync_s q, d;

  // A new level is taken only when stages two and three agree, so a pin caught mid-edge never flickers.
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < N; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.lvl;
endmodule

// File: param_bank.sv
// Bank of selectable parameter words with registered selected values and read port.
`timescale 1ns/1ps
`include "seq_defines.svh"
module param_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire seq_pkg::word_t wdata,
  input wire logic we,
  input wire logic re,
  output seq_pkg::word_t rdata,
  output logic rhit,
  // Selects
  input wire logic [1:0] comp_sel,
  input wire logic [1:0] step_sel,
  input wire logic time_sel,
  // Selected values
  output seq_pkg::word_t comp_value,
  output seq_pkg::word_t preset_speed,
  output seq_pkg::word_t accel_time,
  output seq_pkg::word_t decel_time
);
  import seq_pkg::*;
  typedef struct packed {
    word_t [3:0] comp;
    word_t [2:0] spd;
    word_t [3:0] tim;
    word_t comp_o;
    word_t spd_o;
    word_t acc_o;
    word_t dec_o;
    word_t rd;
    logic hit;
  } bank_s;
  bank_s q, d;
  word_t rv;
  logic rh;

  // Writes, read decode and selection; outputs all come from the register.
  always_comb begin
    d = q;
    rv = 16'h0000;
    rh = 1'b0;
    case (addr)
      `ADDR_COMP0: begin rv = q.comp[0]; rh = 1'b1; if (we) d.comp[0] = wdata; end
      `ADDR_COMP1: begin rv = q.comp[1]; rh = 1'b1; if (we) d.comp[1] = wdata; end
      `ADDR_COMP2: begin rv = q.comp[2]; rh = 1'b1; if (we) d.comp[2] = wdata; end
      `ADDR_COMP3: begin rv = q.comp[3]; rh = 1'b1; if (we) d.comp[3] = wdata; end
      `ADDR_SPD1: begin rv = q.spd[0]; rh = 1'b1; if (we) d.spd[0] = wdata; end
      `ADDR_SPD2: begin rv = q.spd[1]; rh = 1'b1; if (we) d.spd[1] = wdata; end
      `ADDR_SPD3: begin rv = q.spd[2]; rh = 1'b1; if (we) d.spd[2] = wdata; end
      `ADDR_ACC0: begin rv = q.tim[0]; rh = 1'b1; if (we) d.tim[0] = wdata; end
      `ADDR_DEC0: begin rv = q.tim[1]; rh = 1'b1; if (we) d.tim[1] = wdata; end
      `ADDR_ACC1: begin rv = q.tim[2]; rh = 1'b1; if (we) d.tim[2] = wdata; end
      `ADDR_DEC1: begin rv = q.tim[3]; rh = 1'b1; if (we) d.tim[3] = wdata; end
      default: begin rv = 16'h0000; rh = 1'b0; end
    endcase
    d.rd = re ? rv : 16'h0000;
    d.hit = re & rh;
    d.comp_o = q.comp[comp_sel];
    d.spd_o = (step_sel == 2'b00) ? 16'h0000 : q.spd[step_sel - 2'd1];
    d.acc_o = time_sel ? q.tim[2] : q.tim[0];
    d.dec_o = time_sel ? q.tim[3] : q.tim[1];
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.comp <= {4{`RST_COMP}};
      q.comp_o <= `RST_COMP;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rd;
  assign rhit = q.hit;
  assign comp_value = q.comp_o;
  assign preset_speed = q.spd_o;
  assign accel_time = q.acc_o;
  assign decel_time = q.dec_o;
endmodule

// File: seq_input_select.sv
// Sequence input decoder: terminal assignment, mode choice, rotation commands and speed source.
`timescale 1ns/1ps
`include "seq_defines.svh"
module seq_input_select #(
  parameter int N_TERM = 8,
  parameter int SPD_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire seq_pkg::word_t reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output seq_pkg::word_t reg_rdata,
  // Sequence input terminals
  input wire logic [N_TERM-1:0] term_pin,
  // Analog speed command sample, two's complement, same clock domain
  input wire logic [13:0] analog_speed_code,
  // Control mode and pulse train gating
  output seq_pkg::ctrl_mode_e ctrl_mode,
  output logic pulse_accept,
  output logic manual_enable,
  // Rotation
  output logic forward_rotate_cmd,
  output logic reverse_rotate_cmd,
  output logic accel_start,
  output logic decel_start,
  // Selected values
  output logic signed [SPD_W-1:0] speed_target,
  output seq_pkg::word_t comp_value,
  output seq_pkg::word_t accel_time,
  output seq_pkg::word_t decel_time
);
  import seq_pkg::*;

  typedef struct packed {
    logic [N_TERM-1:0][4:0] assign_code;
    logic [2:0] mode_cfg;
    word_t gain;
    word_t max_speed;
    logic forward_prev;
    logic reverse_prev;
    ctrl_mode_e mode;
    motion_e motion;
    logic pulse_ok;
    logic manual;
    logic acc_p;
    logic dec_p;
    logic signed [SPD_W-1:0] speed;
    word_t rd;
  } core_s;
  core_s q, d;

  logic [N_TERM-1:0] term_lvl;
  logic [N_TERM-1:0][31:0] term_hot;
  logic [31:0] fn_lvl;
  word_t bank_rd;
  logic bank_hit;
  word_t preset_speed;
  logic forward_lvl;
  logic reverse_lvl;
  logic forward_rise;
  logic reverse_rise;
  logic mode_sw;
  logic [1:0] comp_sel;
  logic [1:0] step_sel;
  logic time_sel;
  logic signed [30:0] scale_a;
  logic signed [17:0] scale_a_cut;
  logic signed [34:0] scale_b;
  logic signed [SPD_W-1:0] analog_speed;
  logic signed [SPD_W-1:0] preset_signed;
  word_t status_word;
  word_t main_rv;

  // Every terminal passes the synchroniser before any decoding.
  term_sync #(
    .N(N_TERM)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(term_pin),
    .level_out(term_lvl)
  );

  // Each terminal raises the one function its assignment code names; code zero names none.
  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      assign term_hot[g] = term_lvl[g] ? (32'h0000_0001 << q.assign_code[g]) : 32'h0000_0000;
    end
  endgenerate

  // Functions from several terminals combine as an OR; an unassigned function reads OFF.
  always_comb begin
    fn_lvl = 32'h0000_0000;
    for (int i = 0; i < N_TERM; i++) begin
      fn_lvl = fn_lvl | term_hot[i];
    end
    fn_lvl[0] = 1'b0;
  end

  // Function levels picked out of the decoded vector.
  assign comp_sel = {fn_lvl[`FN_COMP_SEL1], fn_lvl[`FN_COMP_SEL0]};
  assign mode_sw = fn_lvl[`FN_MODE_SWITCH];
  assign forward_lvl = fn_lvl[`FN_FORWARD];
  assign reverse_lvl = fn_lvl[`FN_REVERSE];
  assign step_sel = {fn_lvl[`FN_STEP_SEL1], fn_lvl[`FN_STEP_SEL0]};
  assign time_sel = fn_lvl[`FN_TIME_SEL];
  assign forward_rise = forward_lvl & ~q.forward_prev;
  assign reverse_rise = reverse_lvl & ~q.reverse_prev;

  // Selectable parameter words live in their own bank.
  param_bank u_bank (
    .clk(clk),
    .reset(reset),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .we(reg_we),
    .re(reg_re),
    .rdata(bank_rd),
    .rhit(bank_hit),
    .comp_sel(comp_sel),
    .step_sel(step_sel),
    .time_sel(time_sel),
    .comp_value(comp_value),
    .preset_speed(preset_speed),
    .accel_time(accel_time),
    .decel_time(decel_time)
  );

  // The analog code is signed with its full scale at bit 13, so dividing by 2^13 maps
  // plus full scale to about the maximum speed; the one-code shortfall is accepted.
  always_comb begin
    // Operands are widened before the product so no tool can truncate it at operand width.
    scale_a = 31'(signed'(analog_speed_code)) * 31'(signed'({1'b0, q.max_speed}));
    scale_a_cut = scale_a[30:`ADC_FS_SHIFT];
    scale_b = 35'(scale_a_cut) * 35'(signed'({1'b0, q.gain}));
    // A part-select is unsigned, so it is made signed again to keep reverse speeds negative.
    analog_speed = SPD_W'(signed'(scale_b[34:`GAIN_FRAC_SHIFT]));
  end

  // Presets are magnitudes; the direction of the running command gives the sign.
  always_comb begin
    preset_signed = SPD_W'(signed'({1'b0, preset_speed}));
    if (q.motion == MOT_NEGATIVE) begin
      preset_signed = -preset_signed;
    end
  end

  // Status word: mode, motion, pulse gating and the decoded function levels 11 to 19.
  assign status_word = {1'b0, fn_lvl[`FN_TIME_SEL:`FN_PULSE_INHIBIT], q.manual, q.pulse_ok, q.motion, q.mode};

  // Read decode of the registers held here; unmapped addresses read zero.
  always_comb begin
    main_rv = 16'h0000;
    case (reg_addr)
      `ADDR_MODE_CFG: main_rv = {13'h0000, q.mode_cfg};
      `ADDR_GAIN: main_rv = q.gain;
      `ADDR_MAX_SPEED: main_rv = q.max_speed;
      `ADDR_STATUS: main_rv = status_word;
      default: begin
        for (int i = 0; i < N_TERM; i++) begin
          if (reg_addr == 8'(`ADDR_ASSIGN_BASE + i)) begin
            main_rv = {11'h000, q.assign_code[i]};
          end
        end
      end
    endcase
  end

  // Next-state logic of the whole decoder.
  always_comb begin
    d = q;
    d.acc_p = 1'b0;
    d.dec_p = 1'b0;
    d.rd = reg_re ? main_rv : 16'h0000;

    // Register writes.
    if (reg_we) begin
      case (reg_addr)
        `ADDR_MODE_CFG: d.mode_cfg = reg_wdata[2:0];
        `ADDR_GAIN: d.gain = reg_wdata;
        `ADDR_MAX_SPEED: d.max_speed = reg_wdata;
        default: begin
          for (int i = 0; i < N_TERM; i++) begin
            if (reg_addr == 8'(`ADDR_ASSIGN_BASE + i)) begin
              d.assign_code[i] = reg_wdata[4:0];
            end
          end
        end
      endcase
    end

    // Mode choice; settings above 5 fall back to fixed position control.
    case (q.mode_cfg)
      3'd0: d.mode = MODE_POS;
      3'd1: d.mode = MODE_SPD;
      3'd2: d.mode = MODE_TRQ;
      3'd3: d.mode = mode_sw ? MODE_SPD : MODE_POS;
      3'd4: d.mode = mode_sw ? MODE_TRQ : MODE_POS;
      3'd5: d.mode = mode_sw ? MODE_TRQ : MODE_SPD;
      default: d.mode = MODE_POS;
    endcase

    // Inhibit asserted switches to manual operation and shuts the pulse train out.
    d.manual = fn_lvl[`FN_PULSE_INHIBIT];
    d.pulse_ok = ~fn_lvl[`FN_PULSE_INHIBIT];

    // Edge memory for the position-mode start.
    d.forward_prev = forward_lvl;
    d.reverse_prev = reverse_lvl;

    // Rotation command handling by mode.
    if (q.mode == MODE_POS) begin
      if (!fn_lvl[`FN_PULSE_INHIBIT]) begin
        // Manual motion needs the inhibit; the host is expected to raise it first.
        d.motion = MOT_IDLE;
      end else begin
        case (q.motion)
          MOT_IDLE: begin
            // A start needs a clean edge; both rising together keeps the stop.
            if (forward_rise && !reverse_lvl) begin
              d.motion = MOT_POSITIVE;
            end else if (reverse_rise && !forward_lvl) begin
              d.motion = MOT_NEGATIVE;
            end
          end
          MOT_POSITIVE: begin
            // The reverse command is ignored while turning forward.
            if (!forward_lvl) begin
              d.motion = MOT_IDLE;
            end
          end
          MOT_NEGATIVE: begin
            if (!reverse_lvl) begin
              d.motion = MOT_IDLE;
            end
          end
          default: d.motion = MOT_IDLE;
        endcase
      end
    end else begin
      // Speed and torque follow the levels; both on means a deceleration stop.
      if (forward_lvl && !reverse_lvl) begin
        d.motion = MOT_POSITIVE;
      end else if (reverse_lvl && !forward_lvl) begin
        d.motion = MOT_NEGATIVE;
      end else begin
        d.motion = MOT_IDLE;
      end
    end

    // Ramp events mark each change of motion.
    if (d.motion != q.motion) begin
      d.acc_p = (d.motion != MOT_IDLE);
      d.dec_p = (d.motion == MOT_IDLE);
    end

    // Speed source: analog or a preset, chosen the same way in every control mode.
    if (step_sel == 2'b00) begin
      d.speed = analog_speed;
    end else begin
      d.speed = preset_signed;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.mode_cfg <= `RST_MODE_CFG;
      q.gain <= `RST_GAIN;
      q.max_speed <= `RST_MAX_SPEED;
      q.mode <= MODE_POS;
      q.motion <= MOT_IDLE;
      q.pulse_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the register; read data merge the two register banks.
  assign reg_rdata = bank_hit ? bank_rd : q.rd;
  assign ctrl_mode = q.mode;
  assign pulse_accept = q.pulse_ok;
  assign manual_enable = q.manual;
  assign forward_rotate_cmd = (q.motion == MOT_POSITIVE);
  assign reverse_rotate_cmd = (q.motion == MOT_NEGATIVE);
  assign accel_start = q.acc_p;
  assign decel_start = q.dec_p;
  assign speed_target = q.speed;
endmodule

// File: host_terminals.sv
// Host controller model that drives the sequence input terminals from function levels.
`timescale 1ns/1ps
module host_terminals (
  // Clock
  input wire logic clk,
  // Function levels indexed by code minus eleven, and the code held by each terminal
  input wire logic [8:0] fn_level,
  input wire logic [39:0] term_code,
  // Terminal pins
  output logic [7:0] term_pin
);
  logic [4:0] code;

  initial term_pin = 8'h00;

  // Each pin follows the function of its terminal; a terminal without a function rests low.
  // Only manual position moves need the inhibit code, so pulse-only hosts leave it unassigned.
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      code = term_code[5*i +: 5];
      term_pin[i] <= (code >= 5'h0B && code <= 5'h13) ? fn_level[code - 5'h0B] : 1'b0;
    end
  end
endmodule

// File: seq_input_select_props.sv
// Concurrent checks on the ports of the sequence input decoder.
`timescale 1ns/1ps
module seq_input_select_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register read side
  input wire logic reg_re,
  input wire seq_pkg::word_t reg_rdata,
  // Mode, gating and rotation
  input wire seq_pkg::ctrl_mode_e ctrl_mode,
  input wire logic pulse_accept,
  input wire logic manual_enable,
  input wire logic forward_rotate_cmd,
  input wire logic reverse_rotate_cmd,
  input wire logic accel_start,
  input wire logic decel_start
);
  import seq_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Two cycles are needed so a mode change at the same edge is never misread.
  sequence s_pos_gated;
    ctrl_mode == MODE_POS && pulse_accept ##1 ctrl_mode == MODE_POS && pulse_accept;
  endsequence
  sequence s_pos_moving;
    ctrl_mode == MODE_POS && (forward_rotate_cmd || reverse_rotate_cmd) ##1 ctrl_mode == MODE_POS;
  endsequence

  a_gate_exclusive: assert property (pulse_accept != manual_enable)
    else $error("pulse gate and manual enable disagree");
  a_pos_gated_idle: assert property (s_pos_gated |-> !forward_rotate_cmd && !reverse_rotate_cmd)
    else $error("position motion while pulse train accepted");
  a_pos_keeps_motion: assert property (s_pos_moving |-> ($stable(forward_rotate_cmd) && $stable(reverse_rotate_cmd))
    || (!forward_rotate_cmd && !reverse_rotate_cmd))
    else $error("position motion switched direction");
  a_dir_exclusive: assert property (!(forward_rotate_cmd && reverse_rotate_cmd))
    else $error("both directions at once");
  a_accel_on_start: assert property ($rose(forward_rotate_cmd) || $rose(reverse_rotate_cmd) |-> accel_start)
    else $error("start without acceleration pulse");
  a_accel_single: assert property (accel_start |-> (forward_rotate_cmd ^ reverse_rotate_cmd) ##1 !accel_start)
    else $error("acceleration pulse wrong");
  a_decel_on_stop: assert property ($fell(forward_rotate_cmd) && !reverse_rotate_cmd |-> decel_start)
    else $error("stop without deceleration pulse");
  a_decel_cause: assert property (decel_start |-> !forward_rotate_cmd && !reverse_rotate_cmd
    && ($past(forward_rotate_cmd) || $past(reverse_rotate_cmd)) ##1 !decel_start)
    else $error("deceleration pulse wrong");
  a_mode_legal: assert property (ctrl_mode inside {MODE_POS, MODE_SPD, MODE_TRQ})
    else $error("illegal control mode");
  a_rdata_quiet: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule

bind seq_input_select seq_input_select_props u_props (.clk(clk), .reset(reset), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .ctrl_mode(ctrl_mode), .pulse_accept(pulse_accept), .manual_enable(manual_enable),
  .forward_rotate_cmd(forward_rotate_cmd), .reverse_rotate_cmd(reverse_rotate_cmd),
  .accel_start(accel_start), .decel_start(decel_start));

// File: tb.sv
// Self-checking testbench of the sequence input decoder.
`timescale 1ns/1ps
`include "seq_defines.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp); end end
module tb;
  import seq_pkg::*;
  logic clk, reset, reg_we, reg_re, pulse_accept, manual_enable;
  logic forward_rotate_cmd, reverse_rotate_cmd, accel_start, decel_start;
  logic [7:0] reg_addr, term_pin;
  word_t reg_wdata, reg_rdata, comp_value, accel_time, decel_time;
  logic [13:0] analog_speed_code;
  logic [8:0] fn_level;
  logic [39:0] term_code;
  logic signed [23:0] speed_target;
  ctrl_mode_e ctrl_mode;
  int failures, comparisons, n_acc, n_dec;

  seq_input_select u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .term_pin(term_pin),
    .analog_speed_code(analog_speed_code), .ctrl_mode(ctrl_mode), .pulse_accept(pulse_accept),
    .manual_enable(manual_enable), .forward_rotate_cmd(forward_rotate_cmd),
    .reverse_rotate_cmd(reverse_rotate_cmd), .accel_start(accel_start), .decel_start(decel_start),
    .speed_target(speed_target), .comp_value(comp_value), .accel_time(accel_time), .decel_time(decel_time));
  host_terminals u_host (.clk(clk), .fn_level(fn_level), .term_code(term_code), .term_pin(term_pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses last one cycle, so they are counted at every edge.
  always @(posedge clk) begin
    if (accel_start === 1'b1) n_acc++;
    if (decel_start === 1'b1) n_dec++;
  end

  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input word_t exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  // Synchroniser plus bank lag is seven edges; ten leaves margin.
  task automatic settle;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic set_fn(input int code, input logic v);
    @(posedge clk);
    fn_level[code - 11] <= v;
    settle();
  endtask

  task automatic assign_term(input int i, input logic [4:0] code);
    wr(8'h60 + 8'(i), {11'h000, code});
    term_code[5*i +: 5] <= code;
  endtask

  function automatic ctrl_mode_e exp_mode(input int c, input logic s);
    case (c)
      0: return MODE_POS;
      1: return MODE_SPD;
      2: return MODE_TRQ;
      3: return s ? MODE_SPD : MODE_POS;
      4: return s ? MODE_TRQ : MODE_POS;
      5: return s ? MODE_TRQ : MODE_SPD;
      default: return MODE_POS;
    endcase
  endfunction

  task automatic t_reset;
    #1;
    `CHK(pulse_accept, 1'b1)
    `CHK(comp_value, 16'h0001)
    `CHK(ctrl_mode, MODE_POS)
    rd(`ADDR_GAIN, 16'h1000);
    rd(`ADDR_MAX_SPEED, 16'h1000);
    rd(`ADDR_MODE_CFG, 16'h0000);
    rd(8'h02, 16'h0000);
    wr(`ADDR_STATUS, 16'hFFFF);
    rd(`ADDR_STATUS, 16'h0010);
    for (int i = 0; i < 8; i++) assign_term(i, 5'(11 + i));
    $display("test reset done");
  endtask

  task automatic t_comp;
    logic [7:0] addr [4] = '{`ADDR_COMP0, `ADDR_COMP1, `ADDR_COMP2, `ADDR_COMP3};
    for (int s = 0; s < 4; s++) wr(addr[s], 16'hC000 + 16'(s));
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      fn_level[2:1] <= 2'(s);
      settle();
      `CHK(comp_value, 16'hC000 + 16'(s))
    end
    $display("test compensation done");
  endtask

  task automatic t_mode;
    // Settings 6 and 7 lie outside the table and must fall back to fixed position control.
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 2; s++) begin
        wr(`ADDR_MODE_CFG, word_t'(c));
        set_fn(`FN_MODE_SWITCH, s[0]);
        `CHK(ctrl_mode, exp_mode(c, s[0]))
      end
    end
    set_fn(`FN_MODE_SWITCH, 1'b0);
    $display("test mode done");
  endtask

  task automatic t_speed;
    int a0, d0;
    wr(`ADDR_MODE_CFG, 16'h0001);
    a0 = n_acc;
    d0 = n_dec;
    set_fn(`FN_FORWARD, 1'b1);
    `CHK({forward_rotate_cmd, reverse_rotate_cmd}, 2'h2)
    set_fn(`FN_REVERSE, 1'b1);
    `CHK({forward_rotate_cmd, reverse_rotate_cmd}, 2'h0)
    set_fn(`FN_FORWARD, 1'b0);
    `CHK({forward_rotate_cmd, reverse_rotate_cmd}, 2'h1)
    set_fn(`FN_REVERSE, 1'b0);
    `CHK(n_acc - a0, 2)
    `CHK(n_dec - d0, 2)
    $display("test speed rotation done");
  endtask

  task automatic t_pos;
    wr(`ADDR_MODE_CFG, 16'h0000);
    set_fn(`FN_FORWARD, 1'b1);
    `CHK(forward_rotate_cmd, 1'b0)
    set_fn(`FN_FORWARD, 1'b0);
    // The host raises inhibit before any manual command.
    set_fn(`FN_PULSE_INHIBIT, 1'b1);
    `CHK({manual_enable, pulse_accept}, 2'h2)
    set_fn(`FN_FORWARD, 1'b1);
    `CHK({forward_rotate_cmd, reverse_rotate_cmd}, 2'h2)
    set_fn(`FN_REVERSE, 1'b1);
    `CHK({forward_rotate_cmd, reverse_rotate_cmd}, 2'h2)
    set_fn(`FN_FORWARD, 1'b0);
    `CHK({forward_rotate_cmd, reverse_rotate_cmd}, 2'h0)
    set_fn(`FN_REVERSE, 1'b0);
    set_fn(`FN_PULSE_INHIBIT, 1'b0);
    `CHK({manual_enable, pulse_accept}, 2'h1)
    $display("test position rotation done");
  endtask

  task automatic t_source;
    wr(`ADDR_MODE_CFG, 16'h0001);
    wr(`ADDR_SPD1, 16'h0100);
    wr(`ADDR_SPD2, 16'h0200);
    wr(`ADDR_SPD3, 16'h0300);
    analog_speed_code <= 14'h1FFF;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      fn_level[7:6] <= 2'(s);
      settle();
      `CHK(speed_target, (s == 0) ? 24'h000FFF : {14'h0000, 2'(s), 8'h00})
    end
    set_fn(`FN_STEP_SEL1, 1'b0);
    set_fn(`FN_STEP_SEL0, 1'b0);
    wr(`ADDR_GAIN, 16'h0800);
    settle();
    `CHK(speed_target, 24'h0007FF)
    wr(`ADDR_GAIN, 16'h1000);
    analog_speed_code <= 14'h2000;
    settle();
    `CHK(speed_target, 24'hFFF000)
    $display("test speed source done");
  endtask

  task automatic t_time;
    wr(`ADDR_ACC0, 16'h0A0A);
    wr(`ADDR_DEC0, 16'h0B0B);
    wr(`ADDR_ACC1, 16'h1A1A);
    wr(`ADDR_DEC1, 16'h1B1B);
    settle();
    `CHK({accel_time, decel_time}, 32'h0A0A0B0B)
    // Forward loses its terminal, which now carries the time select.
    assign_term(4, 5'h13);
    fn_level[4] <= 1'b1;
    set_fn(`FN_TIME_SEL, 1'b1);
    `CHK({accel_time, decel_time}, 32'h1A1A1B1B)
    `CHK(forward_rotate_cmd, 1'b0)
    $display("test time select done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {reg_we, reg_re, reg_addr, reg_wdata} = '0;
    analog_speed_code = 14'h0000;
    fn_level = 9'h000;
    term_code = 40'h0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_comp();
    t_mode();
    t_speed();
    t_pos();
    t_source();
    t_time();
    give_verdict();
  end

  // All tests take about six hundred cycles; over thirty times that means a hang.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
